// ==== verilog/ecpc_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module ecpc_ctrl (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [ecpc_pkg::AW-1:0] reg_addr,
    input  wire logic [ecpc_pkg::DW-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [ecpc_pkg::DW-1:0] reg_rdata,
    input  wire logic                    error_input_pin_i,
    input  wire logic                    overrange_err,
    input  wire logic                    internal_err,
    input  wire logic                    spi_err,
    output logic                         error_output_pin_o,
    output logic                         error_output_pin_oe,
    output logic                         error_combined,
    output logic                         common_mode_buffer_powerdown,
    output logic                         common_mode_source_select,
    output logic      [4:0]              common_mode_ratio
);

    logic [ecpc_pkg::DW-1:0] src_sel_r;
    logic                    in_en_r;
    logic                    out_en_r;
    logic                    in_stat_r;
    logic                    in_stat_nxt;
    logic                    pd_r;
    logic [4:0]              div_code_r;
    logic                    sel_r;
    logic                    pin_meta_r;
    logic                    pin_sync_r;
    logic                    err_out_r;
    logic                    err_comb_r;
    logic [4:0]              ratio_r;
    logic [ecpc_pkg::DW-1:0] rdata_r;
    logic                    wr_src;
    logic                    wr_pin;
    logic                    wr_cm;
    logic                    int_errs;

    // Divider code to reference fraction numerator
    function automatic logic [4:0] div_ratio(input logic [4:0] code);
        logic [4:0] r;
        r = ecpc_pkg::RATIO_HALF;
        if (code >= ecpc_pkg::DIV_HI_FIRST && code <= ecpc_pkg::DIV_HI_LAST) begin
            r = 5'(ecpc_pkg::RATIO_HI_BASE - code); // RULE7
        end else if (code >= ecpc_pkg::DIV_LO_FIRST && code <= ecpc_pkg::DIV_LO_LAST) begin
            r = 5'(ecpc_pkg::RATIO_LO_BASE - code); // RULE8
        end
        // Code 0, reserved code 1, 29..31 and 20..28 all give half
        return r; // RULE11
    endfunction : div_ratio

    // Register read mux, reserved bits read as zero
    function automatic logic [7:0] rd_value(input logic [7:0] a,
                                             input logic [7:0] s,
                                             input logic [7:0] p,
                                             input logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (a == ecpc_pkg::ADDR_ERR_SRC) begin
            v = s;
        end else if (a == ecpc_pkg::ADDR_ERR_PIN) begin
            v = p;
        end else if (a == ecpc_pkg::ADDR_CM_BUF) begin
            v = c;
        end
        return v;
    endfunction : rd_value

    assign wr_src = reg_wr && (reg_addr == ecpc_pkg::ADDR_ERR_SRC);
    assign wr_pin = reg_wr && (reg_addr == ecpc_pkg::ADDR_ERR_PIN);
    assign wr_cm  = reg_wr && (reg_addr == ecpc_pkg::ADDR_CM_BUF);

    // Error source select: only the three enable bits are kept
    always_ff @(posedge clk) begin
        if (srst) begin
            src_sel_r <= ecpc_pkg::RST_ERR_SRC;
        end else if (wr_src) begin
            src_sel_r <= 8'h00;
            src_sel_r[ecpc_pkg::SRC_OVR_BIT] <= reg_wdata[ecpc_pkg::SRC_OVR_BIT]; // RULE10
            src_sel_r[ecpc_pkg::SRC_INT_BIT] <= reg_wdata[ecpc_pkg::SRC_INT_BIT]; // RULE10
            src_sel_r[ecpc_pkg::SRC_SPI_BIT] <= reg_wdata[ecpc_pkg::SRC_SPI_BIT]; // RULE10
        end
    end

    // Error pin control enables
    always_ff @(posedge clk) begin
        if (srst) begin
            in_en_r  <= ecpc_pkg::RST_ERR_PIN[ecpc_pkg::PIN_IN_BIT];
            out_en_r <= ecpc_pkg::RST_ERR_PIN[ecpc_pkg::PIN_OUT_BIT];
        end else if (wr_pin) begin
            in_en_r  <= reg_wdata[ecpc_pkg::PIN_IN_BIT]; // RULE2
            out_en_r <= reg_wdata[ecpc_pkg::PIN_OUT_BIT]; // RULE4
        end
    end

    // Pin is asynchronous to clk
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= error_input_pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Sticky while enabled; clears while disabled, even with the pin high
    always_comb begin
        in_stat_nxt = 1'b0;
        if (in_en_r) begin
            in_stat_nxt = in_stat_r | pin_sync_r; // RULE1
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_stat_r <= ecpc_pkg::RST_ERR_PIN[ecpc_pkg::PIN_STAT_BIT];
        end else begin
            in_stat_r <= in_stat_nxt; // RULE1
        end
    end

    assign int_errs = (overrange_err & src_sel_r[ecpc_pkg::SRC_OVR_BIT])
                    | (internal_err  & src_sel_r[ecpc_pkg::SRC_INT_BIT])
                    | (spi_err       & src_sel_r[ecpc_pkg::SRC_SPI_BIT]); // RULE10

    // Daisy chained input joins the local errors
    always_ff @(posedge clk) begin
        if (srst) begin
            err_comb_r <= 1'b0;
            err_out_r  <= 1'b0;
        end else begin
            err_comb_r <= int_errs | (in_en_r & in_stat_r); // RULE3
            err_out_r  <= out_en_r & (int_errs | (in_en_r & in_stat_r)); // RULE4
        end
    end

    assign error_output_pin_o  = err_out_r;
    assign error_output_pin_oe = out_en_r; // RULE4
    assign error_combined      = err_comb_r;

    // Common mode buffer control
    always_ff @(posedge clk) begin
        if (srst) begin
            pd_r       <= ecpc_pkg::RST_CM_BUF[ecpc_pkg::CM_PD_BIT];
            div_code_r <= ecpc_pkg::RST_CM_BUF[ecpc_pkg::CM_DIV_HI:ecpc_pkg::CM_DIV_LO];
            sel_r      <= ecpc_pkg::RST_CM_BUF[ecpc_pkg::CM_SEL_BIT];
        end else if (wr_cm) begin
            pd_r       <= reg_wdata[ecpc_pkg::CM_PD_BIT]; // RULE5
            div_code_r <= reg_wdata[ecpc_pkg::CM_DIV_HI:ecpc_pkg::CM_DIV_LO];
            sel_r      <= reg_wdata[ecpc_pkg::CM_SEL_BIT]; // RULE9
        end
    end

    // Supply half is reported as ten twentieths too
    always_ff @(posedge clk) begin
        if (srst) begin
            ratio_r <= ecpc_pkg::RATIO_HALF;
        end else if (sel_r) begin
            ratio_r <= ecpc_pkg::RATIO_HALF; // RULE9
        end else begin
            ratio_r <= div_ratio(div_code_r); // RULE6
        end
    end

    assign common_mode_buffer_powerdown = pd_r; // RULE5
    assign common_mode_source_select    = sel_r;
    assign common_mode_ratio            = ratio_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_value(reg_addr, src_sel_r,
                                {5'h00, in_stat_r, in_en_r, out_en_r}, // RULE1
                                {1'b0, pd_r, div_code_r, sel_r});
        end
    end

    assign reg_rdata = rdata_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_pin_enabled_high;
        in_en_r && pin_sync_r;
    endsequence

    sequence s_stat_seen;
        in_en_r && in_stat_r;
    endsequence

    chk_latch_capture: assert property ( // RULE1
        s_pin_enabled_high |=> in_stat_r)
        else $error("latched input status not captured");

    chk_latch_hold: assert property ( // RULE1
        in_stat_r && in_en_r && !wr_pin |=> in_stat_r [*2])
        else $error("latched input status dropped");

    chk_input_gate: assert property ( // RULE2
        !in_en_r |=> !in_stat_r)
        else $error("status set with error input disabled");

    chk_ext_or: assert property ( // RULE3
        s_stat_seen |=> error_combined)
        else $error("external error not merged");

    chk_out_gate: assert property ( // RULE4
        !out_en_r |=> !error_output_pin_o)
        else $error("error output driven while disabled");

    chk_out_chain: assert property ( // RULE3
        s_pin_enabled_high ##1 (in_en_r && out_en_r && !wr_pin) |=> error_output_pin_o)
        else $error("daisy chained error missing on output");

    chk_src_overrange: assert property ( // RULE10
        overrange_err && src_sel_r[ecpc_pkg::SRC_OVR_BIT] && out_en_r |=> error_output_pin_o)
        else $error("overrange error not routed");

    chk_src_masked: assert property ( // RULE10
        !int_errs && !in_en_r |=> !error_combined)
        else $error("error shown without enabled source");

    chk_pd_write: assert property ( // RULE5
        wr_cm |=> common_mode_buffer_powerdown == $past(reg_wdata[ecpc_pkg::CM_PD_BIT]))
        else $error("power down bit not taken");

    chk_ratio_half: assert property ( // RULE6
        !sel_r && div_code_r == ecpc_pkg::DIV_HALF_CODE |=> common_mode_ratio == 5'h0A)
        else $error("code zero not half reference");

    chk_ratio_top: assert property ( // RULE7
        !sel_r && div_code_r == 5'h02 |=> common_mode_ratio == 5'h13)
        else $error("code two not nineteen twentieths");

    chk_ratio_skip: assert property ( // RULE7
        !sel_r && div_code_r == 5'h0B |=> common_mode_ratio == 5'h09)
        else $error("half scale not skipped");

    chk_ratio_low: assert property ( // RULE8
        !sel_r && div_code_r == 5'h13 |=> common_mode_ratio == 5'h01)
        else $error("lowest code not one twentieth");

    chk_src_fixed: assert property ( // RULE9
        sel_r |=> common_mode_ratio == ecpc_pkg::RATIO_HALF)
        else $error("fixed source not half supply");

    chk_sel_write: assert property ( // RULE9
        wr_cm |=> common_mode_source_select == $past(reg_wdata[ecpc_pkg::CM_SEL_BIT]))
        else $error("source select bit not taken");

    chk_reserved_fall: assert property ( // RULE11
        !sel_r && div_code_r > 5'h13 |=> common_mode_ratio == 5'h0A)
        else $error("reserved code not half reference");

    chk_read_pin: assert property ( // RULE1
        reg_rd && reg_addr == ecpc_pkg::ADDR_ERR_PIN |=>
            reg_rdata == {5'h00, $past(in_stat_r), $past(in_en_r), $past(out_en_r)})
        else $error("error pin register readback wrong");

endmodule : ecpc_ctrl
`default_nettype wire

// ==== shared/ecpc_pkg.sv ====
// Operation
// RULE1: Latch error input, read back at bit 2
// RULE2: Bit 1 enables error input pin
// RULE3: External error ORed with internal errors
// RULE4: Bit 0 enables error output pin drive
// RULE5: Bit 6 powers buffer down when set
// RULE6: Divider code used only when source zero
// RULE7: Codes 2..10 give 19..11, 11 gives 9
// RULE8: Codes 12..19 give 8..1, 29..31 half
// RULE9: Bit 0 selects reference or half supply
// RULE10: Source register enables overrange, internal, interface
// RULE11: Undocumented divider codes fall back to half
package ecpc_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;

    localparam logic [7:0] ADDR_ERR_SRC  = 8'h22;
    localparam logic [7:0] ADDR_ERR_PIN  = 8'h23;
    localparam logic [7:0] ADDR_CM_BUF   = 8'h24;

    localparam logic [7:0] RST_ERR_SRC   = 8'h00;
    localparam logic [7:0] RST_ERR_PIN   = 8'h00;
    localparam logic [7:0] RST_CM_BUF    = 8'h00;

    // Error source select fields
    localparam int unsigned SRC_OVR_BIT  = 5;
    localparam int unsigned SRC_INT_BIT  = 4;
    localparam int unsigned SRC_SPI_BIT  = 3;

    // Error pin control fields
    localparam int unsigned PIN_STAT_BIT = 2;
    localparam int unsigned PIN_IN_BIT   = 1;
    localparam int unsigned PIN_OUT_BIT  = 0;

    // Common mode buffer control fields
    localparam int unsigned CM_PD_BIT    = 6;
    localparam int unsigned CM_DIV_HI    = 5;
    localparam int unsigned CM_DIV_LO    = 1;
    localparam int unsigned CM_SEL_BIT   = 0;

    // Divider codes and ratios in twentieths of the reference
    localparam logic [4:0] DIV_HALF_CODE = 5'h00;
    localparam logic [4:0] DIV_HI_FIRST  = 5'h02;
    localparam logic [4:0] DIV_HI_LAST   = 5'h0A;
    localparam logic [4:0] DIV_LO_FIRST  = 5'h0B;
    localparam logic [4:0] DIV_LO_LAST   = 5'h13;
    localparam logic [4:0] DIV_TOP_FIRST = 5'h1D;
    localparam logic [4:0] RATIO_HALF    = 5'h0A;
    localparam logic [4:0] RATIO_HI_BASE = 5'h15;
    localparam logic [4:0] RATIO_LO_BASE = 5'h14;
endpackage : ecpc_pkg

// ==== sim/ecpc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module ecpc_host (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Strobe spans exactly one rising edge; released write data shows the inverse, address is held
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd_reg
endmodule : ecpc_host
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic       clk  = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic       reg_wr, reg_rd, pin = 1'b0, e_oe, e_o, e_cmb, pd, sel;
    logic [2:0] errs = 3'b000;
    logic [4:0] ratio;
    int         fails = 0;
    int         checks_done = 0;
    int         seed = 32'h39273F68;
    int         cycles = 0;

    always #12.5 clk = ~clk;

    ecpc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ecpc_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .error_input_pin_i(pin),
        .overrange_err(errs[2]), .internal_err(errs[1]), .spi_err(errs[0]),
        .error_output_pin_o(e_o), .error_output_pin_oe(e_oe), .error_combined(e_cmb),
        .common_mode_buffer_powerdown(pd), .common_mode_source_select(sel), .common_mode_ratio(ratio));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Every register and pin output must be back at its reset value
    task automatic check_reset();
        for (int r = 8'h22; r <= 8'h24; r++) begin
            host.rd_reg(8'(r), rd);
            chk(rd, 8'h00);
        end
        chk({1'b0, pd, sel, ratio}, 8'h0A);
        chk({5'h00, e_oe, e_o, e_cmb}, 8'h00);
        $display("reset test done");
    endtask : check_reset

    function automatic logic [4:0] exp_ratio(input logic [4:0] code, input logic s);
        if (s) return 5'h0A;
        if (code >= 5'h02 && code <= 5'h0A) return 5'h15 - code;
        if (code >= 5'h0B && code <= 5'h13) return 5'h14 - code;
        return 5'h0A;
    endfunction : exp_ratio

    // Pin and local errors held low, so the status bit reads 0
    function automatic logic [7:0] exp_read(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h22:   return d & 8'h38;
            8'h23:   return d & 8'h03;
            8'h24:   return d & 8'h7F;
            default: return 8'h00;
        endcase
    endfunction : exp_read

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("[ERR] %0t run did not finish", $time);
            final_report();
        end
    end

    logic [7:0] a, d;
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check_reset();
        // Bit 7 is reserved and is written high to show it is ignored
        for (int c = 0; c < 128; c++) begin
            host.wr_reg(8'h24, {1'b1, 7'(c)});
            repeat (2) @(negedge clk);
            chk({1'b0, pd, sel, ratio}, {1'b0, 1'(c >> 6), 1'(c), exp_ratio(5'(c >> 1), 1'(c))});
        end
        $display("divider test done");
        for (int n = 0; n < 60; n++) begin
            a = ($random(seed) % 4 == 0) ? 8'($random(seed)) : 8'h22 + 8'($unsigned($random(seed)) % 3);
            d = 8'($random(seed));
            host.wr_reg(a, d);
            host.rd_reg(a, rd);
            chk(rd, exp_read(a, d));
            if (a == 8'h24)
                chk({1'b0, pd, sel, ratio}, {1'b0, d[6], d[0], exp_ratio(d[5:1], d[0])});
        end
        $display("random test done");
        // Reset again with registers left non-zero by the random writes
        @(negedge clk) srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check_reset();
        host.wr_reg(8'h22, 8'h00);
        host.wr_reg(8'h23, 8'h03);
        @(negedge clk) pin = 1'b1;
        @(negedge clk) pin = 1'b0;
        repeat (5) @(negedge clk);
        chk({5'h00, e_oe, e_o, e_cmb}, 8'h07);
        host.rd_reg(8'h23, rd);
        chk(rd, 8'h07);
        host.wr_reg(8'h23, 8'h01);
        repeat (3) @(negedge clk);
        host.rd_reg(8'h23, rd);
        chk(rd, 8'h01);
        chk({5'h00, e_oe, e_o, e_cmb}, 8'h04);
        @(negedge clk) pin = 1'b1;
        @(negedge clk) pin = 1'b0;
        repeat (5) @(negedge clk);
        host.rd_reg(8'h23, rd);
        chk(rd, 8'h01);
        chk({7'h00, e_cmb}, 8'h00);
        $display("error pin test done");
        for (int i = 0; i < 3; i++) begin
            host.wr_reg(8'h22, {2'b00, 3'(1 << i), 3'b000});
            @(negedge clk) errs = ~3'(1 << i);
            repeat (3) @(negedge clk);
            chk({6'h00, e_o, e_cmb}, 8'h00);
            @(negedge clk) errs = 3'b111;
            repeat (3) @(negedge clk);
            chk({6'h00, e_o, e_cmb}, 8'h03);
            @(negedge clk) errs = 3'b000;
            repeat (3) @(negedge clk);
            chk({6'h00, e_o, e_cmb}, 8'h00);
        end
        host.wr_reg(8'h23, 8'h00);
        repeat (2) @(negedge clk);
        chk({7'h00, e_oe}, 8'h00);
        $display("error source test done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
